// ---- verilog/smc_pkg.sv ----
/*
 * Package for the supply monitor control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 32-bit APB register bus on pclk at 25 MHz.
 */
`default_nettype none
package smc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_ANALOG  = 8'h04;
  localparam logic [7:0] OFF_CORE    = 8'h08;
  localparam logic [7:0] OFF_REGUL   = 8'h0C;
  localparam logic [7:0] OFF_BANDGAP = 8'h10;
  localparam logic [7:0] OFF_FLL     = 8'h14;
  // ----------------------------------------------------------------
  // Monitor control fields
  // ----------------------------------------------------------------
  localparam int MON_ENABLE   = 0;
  localparam int MON_HYST     = 1;
  localparam int MON_ACTION   = 2;
  localparam int MON_SAMPLING = 3;
  localparam int MON_CLK_EN   = 4;
  localparam int MON_PSEL_LO  = 8;
  localparam int MON_PSEL_W   = 4;
  localparam int MON_THR_LO   = 16;
  localparam int MON_THR_W    = 6;
  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int ST_A_DET   = 0;
  localparam int ST_A_SRDY  = 1;
  localparam int ST_C_DET   = 2;
  localparam int ST_C_SRDY  = 3;
  localparam int ST_LOCK_C  = 4;
  localparam int ST_LOCK_F  = 5;
  // ----------------------------------------------------------------
  // Regulator, bandgap and frequency loop fields
  // ----------------------------------------------------------------
  localparam int REG_LVL_W  = 6;
  localparam int BG_TSEN    = 0;
  localparam int BG_OUTEN   = 1;
  localparam int BG_TRIM_LO = 16;
  localparam int BG_TRIM_W  = 11;
  localparam int FLL_ENABLE = 0;
  localparam int FLL_LLAW   = 1;
  localparam int FLL_STABLE = 2;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Timing: prescaler clock and bus clock
  // ----------------------------------------------------------------
  localparam int PCLK_HZ     = 25_000_000;
  localparam int PRESC_HZ    = 1_000;
  localparam int PRESC_DIV   = PCLK_HZ / PRESC_HZ;
  localparam int SAMPLE_CYC  = 4;
endpackage
`default_nettype wire

// ---- verilog/smc_monitor.sv ----
/*
 * One supply monitor: sampling tick divider, sampling window and
 * detection with hysteresis and reset-or-interrupt action.
 * Assumes a one-cycle 1 kHz prescaler pulse in the pclk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module smc_monitor #(
  parameter int PSEL_W = 4,
  parameter int THR_W  = 6
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              presc_tick,
  input  wire logic              enable,
  input  wire logic              sampling_sel,
  input  wire logic              clk_en,
  input  wire logic              hysteresis,
  input  wire logic              action_int,
  input  wire logic [PSEL_W-1:0] prescale_sel,
  input  wire logic [THR_W-1:0]  threshold,
  input  wire logic [THR_W-1:0]  supply_level,
  output logic                   comparator_on,
  output logic                   detected,
  output logic                   reset_req,
  output logic                   irq_req
);
  localparam int CNT_W = PSEL_W + 2;
  logic [CNT_W-1:0] div_r;
  logic [CNT_W-1:0] div_top;
  logic             samp_tick;
  logic [2:0]       win_r;
  logic             det_r;
  logic             det_d_r;
  logic [THR_W:0]   thr_hi;
  logic             below;

  // ----------------------------------------------------------------
  // Sampling tick
  // ----------------------------------------------------------------
  // Divide by two times the sum of select and one
  assign div_top = CNT_W'(2 * (int'(prescale_sel) + 1) - 1);
  assign samp_tick = presc_tick && clk_en && (div_r == div_top);

  // Tick counter, idle without clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (!clk_en) begin
      div_r <= '0;
    end else if (presc_tick) begin
      div_r <= (div_r == div_top) ? '0 : div_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= '0;
    end else if (samp_tick) begin
      win_r <= 3'(smc_pkg::SAMPLE_CYC);
    end else if (win_r != '0) begin
      win_r <= win_r - 1'b1;
    end
  end

  assign comparator_on = enable && (!sampling_sel || (win_r != '0));

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  // Hysteresis raises release point
  assign thr_hi = {1'b0, threshold} + (hysteresis ? (THR_W+1)'(1) : '0);
  assign below  = det_r ? ({1'b0, supply_level} < thr_hi)
                        : (supply_level < threshold);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_r   <= 1'b0;
      det_d_r <= 1'b0;
    end else begin
      det_d_r <= det_r;
      if (!enable) begin
        det_r <= 1'b0;
      end else if (comparator_on) begin
        det_r <= below;
      end
    end
  end

  assign detected  = det_r;
  assign reset_req = det_r && !action_int;
  assign irq_req   = det_r && !det_d_r && action_int;
endmodule
`default_nettype wire

// ---- verilog/smc_top.sv ----
/*
 * Supply monitor control: APB registers for two supply monitors,
 * regulator level, bandgap trim and frequency loop lock retention.
 * Assumes APB master on pclk; nonvolatile values are steady inputs;
 * monitor sampling and sync run off a 1 kHz tick divided down from pclk.
 */
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module smc_top #(
  parameter int PRESC_DIV = smc_pkg::PRESC_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] analog_user_row,
  input  wire logic [31:0] core_user_row,
  input  wire logic [5:0]  factory_reg_level,
  input  wire logic [10:0] factory_bg_trim,
  input  wire logic [5:0]  analog_supply_rail,
  input  wire logic [5:0]  core_supply_rail,
  input  wire logic        fll_ref_clk_ok,
  input  wire logic        fll_coarse_lock_in,
  input  wire logic        fll_fine_lock_in,
  output logic             analog_comparator_on,
  output logic             core_comparator_on,
  output logic             monitor_reset_req,
  output logic             analog_monitor_irq,
  output logic             core_monitor_irq,
  output logic [5:0]       regulator_output_level,
  output logic [10:0]      bandgap_trim,
  output logic             temp_sensor_enable,
  output logic             bandgap_to_converter_enable,
  output logic             fll_enable,
  output logic             fll_drift_track
);
  localparam int PW = smc_pkg::MON_PSEL_W;
  localparam int TW = smc_pkg::MON_THR_W;
  localparam int DIV_W = $clog2(PRESC_DIV);

  typedef enum logic [1:0] {
    SMC_IDLE  = 2'b00,
    SMC_WAIT  = 2'b01,
    SMC_APPLY = 2'b11
  } smc_sync_t;

  logic             init_r;
  logic [31:0]      a_ctrl_r;
  logic [31:0]      c_ctrl_r;
  logic [31:0]      a_pend_r;
  logic [31:0]      c_pend_r;
  smc_sync_t        a_st_r;
  smc_sync_t        c_st_r;
  logic [5:0]       reg_level_r;
  logic [31:0]      bg_r;
  logic [2:0]       fll_r;
  logic             lock_c_r;
  logic             lock_f_r;
  logic [DIV_W-1:0] presc_r;
  logic             presc_tick;
  logic             wr_en;
  logic             a_srdy;
  logic             c_srdy;
  logic             a_det;
  logic             c_det;
  logic             a_rst;
  logic             c_rst;
  logic [31:0]      rd_nxt;
  logic             addr_ok;

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // Zero wait states; read data is registered at setup
  // so it stands unchanged through the access phase
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  always_comb begin
    rd_nxt  = smc_pkg::RESET_ZERO;
    addr_ok = 1'b1;
    case (paddr)
      smc_pkg::OFF_STATUS: begin
        rd_nxt[smc_pkg::ST_A_DET]  = a_det;
        rd_nxt[smc_pkg::ST_C_DET]  = c_det;
        rd_nxt[smc_pkg::ST_A_SRDY] = a_srdy;
        rd_nxt[smc_pkg::ST_C_SRDY] = c_srdy;
        rd_nxt[smc_pkg::ST_LOCK_C] = lock_c_r;
        rd_nxt[smc_pkg::ST_LOCK_F] = lock_f_r;
      end
      smc_pkg::OFF_ANALOG:  rd_nxt = a_ctrl_r;
      smc_pkg::OFF_CORE:    rd_nxt = c_ctrl_r;
      smc_pkg::OFF_REGUL:   rd_nxt = {26'h000_0000, reg_level_r};
      smc_pkg::OFF_BANDGAP: rd_nxt = bg_r;
      smc_pkg::OFF_FLL:     rd_nxt = {29'h0000_0000, fll_r};
      default:              addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= smc_pkg::RESET_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, 1 kHz tick
  // ----------------------------------------------------------------
  // Free running, so the tick phase never depends
  // on when software last wrote a register
  // Tick from the always-on prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= '0;
    end else if (presc_r == DIV_W'(PRESC_DIV - 1)) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end
  assign presc_tick = (presc_r == DIV_W'(PRESC_DIV - 1));

  // ----------------------------------------------------------------
  // Load after reset, one cycle after release
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Monitor control and write sync
  // ----------------------------------------------------------------
  // Sync completes the cycle after a prescaler tick, modelling the slow domain
  // Dropped rather than stalled: a stall could hold the bus
  // for a whole tick period, so software polls ready instead
  assign a_srdy = (a_st_r == SMC_IDLE);
  assign c_srdy = (c_st_r == SMC_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ctrl_r <= smc_pkg::RESET_ZERO;
      a_pend_r <= smc_pkg::RESET_ZERO;
      a_st_r   <= SMC_IDLE;
    end else if (init_r) begin
      a_ctrl_r <= analog_user_row & ~(32'h0000_0001 << smc_pkg::MON_SAMPLING);
    end else begin
      case (a_st_r)
        SMC_IDLE: begin
          if (wr_en && paddr == smc_pkg::OFF_ANALOG) begin
            a_pend_r <= pwdata;
            a_st_r   <= SMC_WAIT;
          end
        end
        SMC_WAIT:  if (presc_tick) a_st_r <= SMC_APPLY;
        SMC_APPLY: begin
          a_ctrl_r <= a_pend_r;
          a_st_r   <= SMC_IDLE;
        end
        default:   a_st_r <= SMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_ctrl_r <= smc_pkg::RESET_ZERO;
      c_pend_r <= smc_pkg::RESET_ZERO;
      c_st_r   <= SMC_IDLE;
    end else if (init_r) begin
      c_ctrl_r <= core_user_row & ~(32'h0000_0001 << smc_pkg::MON_SAMPLING);
    end else begin
      case (c_st_r)
        SMC_IDLE: begin
          if (wr_en && paddr == smc_pkg::OFF_CORE) begin
            c_pend_r <= pwdata;
            c_st_r   <= SMC_WAIT;
          end
        end
        SMC_WAIT:  if (presc_tick) c_st_r <= SMC_APPLY;
        SMC_APPLY: begin
          c_ctrl_r <= c_pend_r;
          c_st_r   <= SMC_IDLE;
        end
        default:   c_st_r <= SMC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  smc_monitor #(.PSEL_W(PW), .THR_W(TW)) u_analog (
    .pclk          (pclk),
    .presetn       (presetn),
    .presc_tick    (presc_tick),
    .enable        (a_ctrl_r[smc_pkg::MON_ENABLE]),
    .sampling_sel  (a_ctrl_r[smc_pkg::MON_SAMPLING]),
    .clk_en        (a_ctrl_r[smc_pkg::MON_CLK_EN]),
    .hysteresis    (a_ctrl_r[smc_pkg::MON_HYST]),
    .action_int    (a_ctrl_r[smc_pkg::MON_ACTION]),
    .prescale_sel  (a_ctrl_r[smc_pkg::MON_PSEL_LO +: PW]),
    .threshold     (a_ctrl_r[smc_pkg::MON_THR_LO +: TW]),
    .supply_level  (analog_supply_rail),
    .comparator_on (analog_comparator_on),
    .detected      (a_det),
    .reset_req     (a_rst),
    .irq_req       (analog_monitor_irq)
  );

  smc_monitor #(.PSEL_W(PW), .THR_W(TW)) u_core (
    .pclk          (pclk),
    .presetn       (presetn),
    .presc_tick    (presc_tick),
    .enable        (c_ctrl_r[smc_pkg::MON_ENABLE]),
    .sampling_sel  (c_ctrl_r[smc_pkg::MON_SAMPLING]),
    .clk_en        (c_ctrl_r[smc_pkg::MON_CLK_EN]),
    .hysteresis    (c_ctrl_r[smc_pkg::MON_HYST]),
    .action_int    (c_ctrl_r[smc_pkg::MON_ACTION]),
    .prescale_sel  (c_ctrl_r[smc_pkg::MON_PSEL_LO +: PW]),
    .threshold     (c_ctrl_r[smc_pkg::MON_THR_LO +: TW]),
    .supply_level  (core_supply_rail),
    .comparator_on (core_comparator_on),
    .detected      (c_det),
    .reset_req     (c_rst),
    .irq_req       (core_monitor_irq)
  );

  // Either monitor may pull the device reset
  assign monitor_reset_req = a_rst || c_rst;

  // ----------------------------------------------------------------
  // Regulator and bandgap
  // ----------------------------------------------------------------
  // Factory inputs are steady, one sample suffices
  // Factory regulator level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_level_r <= 6'h00;
    end else if (init_r) begin
      reg_level_r <= factory_reg_level;
    end else if (wr_en && paddr == smc_pkg::OFF_REGUL) begin
      reg_level_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_r <= smc_pkg::RESET_ZERO;
    end else if (init_r) begin
      bg_r <= {5'h00, factory_bg_trim, 16'h0000};
    end else if (wr_en && paddr == smc_pkg::OFF_BANDGAP) begin
      bg_r <= {5'h00, pwdata[26:16], 14'h0000, pwdata[1:0]};
    end
  end

  // Only trim and the two enables are writable
  assign regulator_output_level = reg_level_r;
  assign bandgap_trim           = bg_r[smc_pkg::BG_TRIM_LO +: smc_pkg::BG_TRIM_W];
  assign temp_sensor_enable     = bg_r[smc_pkg::BG_TSEN];
  assign bandgap_to_converter_enable = bg_r[smc_pkg::BG_OUTEN];

  // ----------------------------------------------------------------
  // Frequency loop lock retention
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fll_r <= 3'h0;
    end else if (wr_en && paddr == smc_pkg::OFF_FLL) begin
      fll_r <= pwdata[2:0];
    end
  end

  // Lock inputs are levels from the loop itself
  // Locks set wins; disable with lose-lock clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_c_r <= 1'b0;
      lock_f_r <= 1'b0;
    end else if (fll_r[smc_pkg::FLL_ENABLE]) begin
      if (fll_coarse_lock_in) lock_c_r <= 1'b1;
      // Fine only after coarse
      if (fll_fine_lock_in && lock_c_r) lock_f_r <= 1'b1;
    end else if (fll_r[smc_pkg::FLL_LLAW]) begin
      lock_c_r <= 1'b0;
      lock_f_r <= 1'b0;
    end
  end

  assign fll_enable = fll_r[smc_pkg::FLL_ENABLE];
  // Drift tracking gated by stable hold
  assign fll_drift_track = fll_r[smc_pkg::FLL_ENABLE] && fll_ref_clk_ok
                           && !fll_r[smc_pkg::FLL_STABLE] && lock_f_r;
endmodule
`default_nettype wire

// ---- tb/smc_top_props.sv ----
/*
 * Checker for the supply monitor control top: register driven
 * outputs, interrupt pulses and drift tracking.
 * Assumes it is bound onto smc_top, whose port names it shares.
 */
`timescale 1ns/10ps
`default_nettype none
module smc_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        analog_comparator_on,
  input wire logic        core_comparator_on,
  input wire logic        analog_monitor_irq,
  input wire logic        core_monitor_irq,
  input wire logic        fll_enable,
  input wire logic        fll_ref_clk_ok,
  input wire logic        fll_drift_track,
  input wire logic        temp_sensor_enable,
  input wire logic        bandgap_to_converter_enable,
  input wire logic [10:0] bandgap_trim
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        wr_bg;
  logic        wr_fll;
  logic [31:0] wd_q;
  assign wr_bg  = psel && penable && pwrite && pready && paddr == smc_pkg::OFF_BANDGAP;
  assign wr_fll = psel && penable && pwrite && pready && paddr == smc_pkg::OFF_FLL;
  // Write data of the last edge, so no part-select inside $past
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_q <= smc_pkg::RESET_ZERO;
    else wd_q <= pwdata;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_TSEN_WRITE: assert property (
    wr_bg |=> temp_sensor_enable == wd_q[smc_pkg::BG_TSEN]) else $error("temp enable wrong");
  AST_BGOUT_WRITE: assert property (
    wr_bg |=> bandgap_to_converter_enable == wd_q[smc_pkg::BG_OUTEN])
    else $error("bandgap route wrong");
  AST_TRIM_WRITE: assert property (
    wr_bg |=> bandgap_trim == wd_q[smc_pkg::BG_TRIM_LO +: smc_pkg::BG_TRIM_W])
    else $error("trim not replaced");
  AST_FLL_WRITE: assert property (
    wr_fll |=> fll_enable == wd_q[smc_pkg::FLL_ENABLE]) else $error("loop enable wrong");
  AST_DRIFT_GATE: assert property (
    fll_drift_track |-> fll_enable && fll_ref_clk_ok) else $error("drift tracking ungated");
  AST_A_IRQ_PULSE: assert property (
    analog_monitor_irq |=> !analog_monitor_irq) else $error("analog irq too long");
  AST_C_IRQ_PULSE: assert property (
    core_monitor_irq |=> !core_monitor_irq) else $error("core irq too long");
  AST_A_IRQ_ON: assert property (
    analog_monitor_irq |-> $past(analog_comparator_on) || $past(analog_comparator_on, 2))
    else $error("analog irq while monitor off");
  AST_C_IRQ_ON: assert property (
    core_monitor_irq |-> $past(core_comparator_on) || $past(core_comparator_on, 2))
    else $error("core irq while monitor off");
endmodule
bind smc_top smc_top_props smc_top_props_inst (.*);
`default_nettype wire

// ---- tb/smc_top_tb.sv ----
/*
 * Self-checking bench for the supply monitor control top.
 * Assumes smc_pkg, smc_top and the bound checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module smc_top_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Slow enough that three bus reads fit inside one sync wait
  localparam int DIV = 40;
  localparam logic [7:0] ST = smc_pkg::OFF_STATUS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, analog_user_row, core_user_row, rd;
  logic [5:0]  factory_reg_level, analog_supply_rail, core_supply_rail;
  logic [5:0]  regulator_output_level;
  logic [10:0] factory_bg_trim, bandgap_trim;
  logic        fll_ref_clk_ok, fll_coarse_lock_in, fll_fine_lock_in;
  logic        analog_comparator_on, core_comparator_on, monitor_reset_req;
  logic        analog_monitor_irq, core_monitor_irq, temp_sensor_enable;
  logic        bandgap_to_converter_enable, fll_enable, fll_drift_track;
  logic [3:0]  mon;
  int          errors, comparisons, n;
  assign mon = {core_comparator_on, monitor_reset_req, analog_monitor_irq, core_monitor_irq};

  smc_top #(.PRESC_DIV(DIV)) smc_top_inst (.*);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_srdy(input int b);
    int k;
    k = 0;
    do begin
      xfer(ST, 1'b0, 32'h0000_0000);
      k++;
    end while (rd[b] !== 1'b1 && k < 200);
    chk(rd[b], 1'b1);
  endtask

  // Sampled on the falling edge, clear of register updates
  task automatic wait_lvl(input int i, input logic v);
    n = 0;
    while (mon[i] !== v && n < 2000) begin
      @(negedge pclk);
      n++;
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    analog_user_row = 32'h0014_000D;
    core_user_row = 32'h000A_0001;
    factory_reg_level = 6'h2A;
    factory_bg_trim = 11'h5A5;
    analog_supply_rail = 6'h3F;
    core_supply_rail = 6'h3F;
    fll_ref_clk_ok = 1'b1;
    fll_coarse_lock_in = 1'b0;
    fll_fine_lock_in = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    xfer(smc_pkg::OFF_ANALOG, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0014_0005);
    xfer(smc_pkg::OFF_CORE, 1'b0, 32'h0000_0000);
    chk(rd, 32'h000A_0001);
    chk(regulator_output_level, 6'h2A);
    chk(bandgap_trim, 11'h5A5);
    chk({analog_comparator_on, core_comparator_on}, 2'h3);
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[3:0], 4'hA);
    xfer(8'h40, 1'b0, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    // Analog brown-out with interrupt action
    analog_supply_rail <= 6'd19;
    wait_lvl(1, 1'b1);
    chk({analog_monitor_irq, monitor_reset_req}, 2'h2);
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b1);
    analog_supply_rail <= 6'd20;
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b0);
    // Sync: a write right after a completed sync sees a full wait
    xfer(smc_pkg::OFF_ANALOG, 1'b1, 32'h0014_0005);
    wait_srdy(1);
    xfer(smc_pkg::OFF_ANALOG, 1'b1, 32'h0014_0007);
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[1], 1'b0);
    xfer(smc_pkg::OFF_ANALOG, 1'b1, 32'h0000_0000);
    wait_srdy(1);
    xfer(smc_pkg::OFF_ANALOG, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0014_0007);
    analog_supply_rail <= 6'd19;
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b1);
    analog_supply_rail <= 6'd20;
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b1);
    analog_supply_rail <= 6'd21;
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b0);
    // Core brown-out with reset action
    core_supply_rail <= 6'd9;
    wait_lvl(2, 1'b1);
    chk({monitor_reset_req, core_monitor_irq}, 2'h2);
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[2], 1'b1);
    core_supply_rail <= 6'd10;
    wait_lvl(2, 1'b0);
    chk(monitor_reset_req, 1'b0);
    // Sampling mode: select 1 with the clock off, then clock on
    wait_srdy(3);
    xfer(smc_pkg::OFF_CORE, 1'b1, 32'h000A_0109);
    wait_srdy(3);
    xfer(smc_pkg::OFF_CORE, 1'b1, 32'h000A_0119);
    wait_srdy(3);
    wait_lvl(3, 1'b0);
    wait_lvl(3, 1'b1);
    wait_lvl(3, 1'b0);
    chk(n, smc_pkg::SAMPLE_CYC);
    wait_lvl(3, 1'b1);
    chk(n + smc_pkg::SAMPLE_CYC, 4 * DIV);
    xfer(smc_pkg::OFF_CORE, 1'b1, 32'h000A_0109);
    wait_srdy(3);
    wait_lvl(3, 1'b0);
    wait_lvl(3, 1'b1);
    chk(core_comparator_on, 1'b0);
    // Bandgap, temperature sensor and trim override
    for (int i = 0; i < 2; i++) begin
      xfer(smc_pkg::OFF_BANDGAP, 1'b1, i ? 32'h0000_0000 : 32'h0155_0003);
      @(negedge pclk);
      chk({temp_sensor_enable, bandgap_to_converter_enable}, i ? 2'h0 : 2'h3);
      chk(bandgap_trim, i ? 11'h000 : 11'h155);
    end
    // Loop lock kept or lost across a disable
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0001);
    fll_coarse_lock_in <= 1'b1;
    fll_fine_lock_in <= 1'b1;
    xfer(ST, 1'b0, 32'h0000_0000);
    @(negedge pclk);
    chk(fll_drift_track, 1'b1);
    @(posedge pclk);
    fll_coarse_lock_in <= 1'b0;
    fll_fine_lock_in <= 1'b0;
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0000);
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0001);
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[5:4], 2'h3);
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0005);
    @(negedge pclk);
    chk(fll_drift_track, 1'b0);
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0003);
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0002);
    xfer(smc_pkg::OFF_FLL, 1'b1, 32'h0000_0001);
    xfer(ST, 1'b0, 32'h0000_0000);
    chk(rd[5:4], 2'h0);
    wrap_up();
  end

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
